// >>> hdl/cmd_pkg.sv
// constants shared by the serial setup command parser and its fifo
// assumes a single 25 MHz core clock and a synchronous active-high reset
package cmd_pkg;

  // serial framing and timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int BAUD         = 19200;
  localparam int DATA_BITS    = 8;
  localparam int STOP_BITS    = 1;
  localparam int BIT_CYC      = CLK_HZ / BAUD;
  localparam int HALF_CYC     = BIT_CYC / 2;
  localparam int FRAME_BITS   = 1 + DATA_BITS + STOP_BITS;

  // halt sequence length
  localparam int BANG_RUN     = 5;

  // characters
  localparam logic [7:0] CH_BANG   = 8'h21;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NINE   = 8'h39;

  // three-letter command words, first letter in the top byte
  localparam logic [23:0] CMD_AVE = 24'h617665;
  localparam logic [23:0] CMD_CLK = 24'h636c6b;
  localparam logic [23:0] CMD_DAT = 24'h646174;
  localparam logic [23:0] CMD_EMC = 24'h656d63;
  localparam logic [23:0] CMD_GET = 24'h676574;
  localparam logic [23:0] CMD_PKT = 24'h706b74;
  localparam logic [23:0] CMD_SET = 24'h736574;
  localparam logic [23:0] CMD_INT = 24'h696e74;
  localparam logic [23:0] CMD_STO = 24'h73746f;
  localparam logic [23:0] CMD_MNU = 24'h6d6e75;
  localparam logic [23:0] CMD_RUN = 24'h72756e;

  // argument limits
  localparam int          CMD_LETTERS = 3;
  localparam int          TIME_DIGITS = 6;
  localparam logic [20:0] ARG_MAX     = 21'h00ffff;
  localparam logic [7:0]  HOUR_MAX    = 8'h23;
  localparam logic [7:0]  MINSEC_MAX  = 8'h59;
  localparam logic [7:0]  DAY_MIN     = 8'h01;
  localparam logic [7:0]  DAY_MAX     = 8'h31;
  localparam logic [7:0]  MONTH_MIN   = 8'h01;
  localparam logic [7:0]  MONTH_MAX   = 8'h12;

  // configuration reset values
  localparam logic [15:0] AVE_RST = 16'h0001;
  localparam logic [15:0] PKT_RST = 16'h0001;
  localparam logic [15:0] SET_RST = 16'h0001;
  localparam logic [23:0] INT_RST = 24'h000001;
  localparam logic [23:0] RTC_RST = 24'h000000;

  // replies, text in the top bytes
  localparam int          MSG_W        = 64;
  localparam logic [63:0] TXT_MENU     = {"menu", CH_CR, CH_LF, 16'h0000};
  localparam logic [63:0] TXT_ETX      = {"etx", CH_CR, CH_LF, 24'h000000};
  localparam logic [63:0] TXT_ERR      = {"?", CH_CR, CH_LF, 40'h0000000000};
  localparam logic [2:0]  LEN_MENU     = 3'h6;
  localparam logic [2:0]  LEN_ETX      = 3'h5;
  localparam logic [2:0]  LEN_ERR      = 3'h3;

  // dump fifo: log byte plus last-byte flag
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    MSG_MENU,
    MSG_ETX,
    MSG_ERR
  } msg_t;

endpackage

// >>> hdl/fifo_if.sv
// valid/ready stream pair around the dump fifo
// assumes both sides sit on the core clock
`timescale 1ns/1ps
interface fifo_if #(
  parameter int WIDTH = 9
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport store (
    input  in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data
  );
endinterface

// >>> hdl/byte_fifo.sv
// synchronous fifo with a registered read stage
// assumes one clock; depth must be a power of two
`timescale 1ns/1ps
module byte_fifo
  import cmd_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  fifo_if.store    fq
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             out_vld_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             load;

  assign fq.in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign push         = fq.in_valid && fq.in_ready;
  // refill the output stage when it is empty or being taken
  assign load         = (cnt_ff != '0) && (!out_vld_ff || fq.out_ready);
  assign fq.out_valid = out_vld_ff;
  assign fq.out_data  = out_data_ff;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= fq.in_data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      out_vld_ff  <= 1'b0;
      out_data_ff <= '0;
    end else if (load) begin
      out_vld_ff  <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (fq.out_ready) begin
      out_vld_ff  <= 1'b0;
    end
  end
endmodule

// >>> hdl/serial_setup_command_parser.sv
// serial setup command interpreter: uart, parser, config, erase and dump
// assumes rx_i is already synchronous to core_clk_i; memory engine is outside
//
// Overview of operation
// - the link runs 19200 baud, 8 data bits, no parity, 1 stop bit, no flow control.
// - five exclamation marks stop sampling and enter setup, where commands are taken.
// - the averaging command takes 1 to 65535 and sets measurements per output value.
// - the clock command takes hhmmss and loads the real-time clock time.
// - the date command takes ddmmyy and loads the real-time clock date.
// - the erase command clears the log memory and sends the menu when finished.
// - the dump command streams all logged records out and then sends etx.
// - the packet command takes 0 to 65535 readings per packet.
// - the set command takes 0 to 65535 packets per burst.
// - the interval command takes hhmmss as the spacing of packets in a burst.
// - the store command saves the current configuration to flash.
`timescale 1ns/1ps
module serial_setup_command_parser
  import cmd_pkg::*;
#(
  parameter int DUMP_DEPTH = FIFO_DEPTH,
  // bit time in core clocks; a bench may shorten it to keep runs brief
  parameter int BIT_TIME   = BIT_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rx_i,
  output logic             tx_o,
  output logic             sampling_o,
  output logic [15:0]      avg_count_o,
  output logic [15:0]      pkt_readings_o,
  output logic [15:0]      burst_packets_o,
  output logic [23:0]      pkt_interval_o,
  output logic [23:0]      rtc_time_o,
  output logic             rtc_time_load_o,
  output logic [23:0]      rtc_date_o,
  output logic             rtc_date_load_o,
  output logic             erase_req_o,
  input  wire logic        erase_done_i,
  output logic             dump_req_o,
  input  wire logic [7:0]  log_data_i,
  input  wire logic        log_last_i,
  input  wire logic        log_valid_i,
  output logic             log_ready_o,
  output logic             save_cfg_o,
  output logic             cmd_error_o
);
  localparam int CW = $clog2(BIT_TIME + 1);

  // below 8 clocks the stop-bit sample and reply turnaround no longer fit in a bit
  if (DUMP_DEPTH < 2 || BIT_TIME < 8) begin : g_chk
    $error("dump fifo depth or bit time too small");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;
  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_CMD, ST_ARG, ST_SKIP, ST_ERASE, ST_DUMP, ST_MSG
  } st_t;

  // receiver
  rx_st_t          rx_st_ff;
  logic [CW-1:0]   rx_cnt_ff;
  logic [2:0]      rx_bit_ff;
  logic [7:0]      rx_sh_ff;
  logic            rx_vld_ff;
  logic [7:0]      rx_byte_ff;

  // transmitter
  logic [9:0]      tx_sh_ff;
  logic [3:0]      tx_bits_ff;
  logic [CW-1:0]   tx_cnt_ff;
  logic            tx_busy;
  logic            tx_go;
  logic [7:0]      tx_byte;

  // parser
  st_t             st_ff;
  logic [2:0]      bang_cnt_ff;
  logic            bang_hit;
  logic [23:0]     cmd_ff;
  logic [1:0]      ltr_ff;
  logic [16:0]     arg_val_ff;
  logic [23:0]     arg_bcd_ff;
  logic [2:0]      arg_cnt_ff;
  logic            arg_bad_ff;
  logic            arg_ovf_ff;
  msg_t            msg_ff;
  logic [2:0]      msg_idx_ff;
  logic [2:0]      msg_len;
  logic [63:0]     msg_txt;
  logic            msg_end;
  logic            is_digit;
  logic [20:0]     val_x10;
  logic            exec;
  logic            cmd_ok;
  logic            num_ok;
  logic            six_ok;
  logic            no_arg;
  logic            dump_last;

  fifo_if #(.WIDTH(FIFO_WIDTH)) dq ();

  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DUMP_DEPTH)
  ) u_dump_fifo (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .fq         (dq)
  );

  assign dq.in_valid = log_valid_i;
  assign dq.in_data  = {log_last_i, log_data_i};
  assign log_ready_o = dq.in_ready;

  // receiver: mid-bit sampling, frames with a low stop bit are dropped
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_st_ff   <= RX_IDLE;
      rx_cnt_ff  <= '0;
      rx_bit_ff  <= '0;
      rx_sh_ff   <= '0;
      rx_vld_ff  <= 1'b0;
      rx_byte_ff <= '0;
    end else begin
      rx_vld_ff <= 1'b0;
      case (rx_st_ff)
        RX_IDLE: begin
          if (!rx_i) begin
            rx_st_ff  <= RX_START;
            rx_cnt_ff <= CW'(BIT_TIME / 2 - 1);
          end
        end
        RX_START: begin
          if (rx_cnt_ff != '0) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
          end else if (rx_i) begin
            rx_st_ff <= RX_IDLE; // glitch, not a start bit
          end else begin
            rx_st_ff  <= RX_DATA;
            rx_bit_ff <= '0;
            rx_cnt_ff <= CW'(BIT_TIME - 1);
          end
        end
        RX_DATA: begin
          if (rx_cnt_ff != '0) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
          end else begin
            rx_sh_ff  <= {rx_i, rx_sh_ff[7:1]};
            rx_cnt_ff <= CW'(BIT_TIME - 1);
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == 3'(DATA_BITS - 1)) begin
              rx_st_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt_ff != '0) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
          end else begin
            rx_st_ff   <= RX_IDLE;
            rx_vld_ff  <= rx_i;
            rx_byte_ff <= rx_sh_ff;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // transmitter: start, 8 data lsb first, 1 stop, no handshake lines
  assign tx_busy = tx_bits_ff != '0;
  assign tx_o    = tx_sh_ff[0];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_sh_ff   <= '1;
      tx_bits_ff <= '0;
      tx_cnt_ff  <= '0;
    end else if (tx_go) begin
      tx_sh_ff   <= {1'b1, tx_byte, 1'b0};
      tx_bits_ff <= 4'(FRAME_BITS);
      tx_cnt_ff  <= CW'(BIT_TIME - 1);
    end else if (tx_busy) begin
      if (tx_cnt_ff != '0) begin
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
      end else begin
        tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
        tx_bits_ff <= tx_bits_ff - 1'b1;
        tx_cnt_ff  <= CW'(BIT_TIME - 1);
      end
    end
  end

  // halt detector runs in every state, so a host hammering '!' after power-up gets in
  assign bang_hit = rx_vld_ff && rx_byte_ff == CH_BANG
                    && bang_cnt_ff == 3'(BANG_RUN - 1);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bang_cnt_ff <= '0;
    end else if (rx_vld_ff) begin
      if (rx_byte_ff != CH_BANG || bang_hit) begin
        bang_cnt_ff <= '0;
      end else begin
        bang_cnt_ff <= bang_cnt_ff + 1'b1;
      end
    end
  end

  // reply text and the byte feeding the transmitter
  always_comb begin
    case (msg_ff)
      MSG_MENU: begin
        msg_txt = TXT_MENU;
        msg_len = LEN_MENU;
      end
      MSG_ETX: begin
        msg_txt = TXT_ETX;
        msg_len = LEN_ETX;
      end
      default: begin
        msg_txt = TXT_ERR;
        msg_len = LEN_ERR;
      end
    endcase
  end

  always_comb begin
    tx_go        = 1'b0;
    tx_byte      = msg_txt[MSG_W-1-8*msg_idx_ff -: 8];
    dq.out_ready = 1'b0;
    if (st_ff == ST_MSG) begin
      tx_go = !tx_busy;
    end else if (st_ff == ST_DUMP) begin
      tx_go        = !tx_busy && dq.out_valid;
      tx_byte      = dq.out_data[7:0];
      dq.out_ready = !tx_busy;
    end
  end

  assign msg_end   = tx_go && msg_idx_ff == msg_len - 1'b1;
  assign dump_last = st_ff == ST_DUMP && tx_go && dq.out_data[8];

  // argument checks, evaluated on the terminating return
  assign is_digit = rx_byte_ff >= CH_ZERO && rx_byte_ff <= CH_NINE;
  assign val_x10  = 21'(arg_val_ff) * 21'd10 + 21'(rx_byte_ff - CH_ZERO);
  assign exec     = rx_vld_ff && rx_byte_ff == CH_CR
                    && ((st_ff == ST_CMD && ltr_ff == 2'(CMD_LETTERS)) || st_ff == ST_ARG);
  assign no_arg   = st_ff == ST_CMD;
  assign num_ok   = !no_arg && arg_cnt_ff != '0 && !arg_bad_ff && !arg_ovf_ff;
  assign six_ok   = !no_arg && arg_cnt_ff == 3'(TIME_DIGITS) && !arg_bad_ff;

  always_comb begin
    case (cmd_ff)
      CMD_AVE: cmd_ok = num_ok && arg_val_ff != '0;
      CMD_PKT: cmd_ok = num_ok;
      CMD_SET: cmd_ok = num_ok;
      CMD_CLK, CMD_INT: cmd_ok = six_ok && arg_bcd_ff[23:16] <= HOUR_MAX
                                 && arg_bcd_ff[15:8] <= MINSEC_MAX
                                 && arg_bcd_ff[7:0] <= MINSEC_MAX;
      CMD_DAT: cmd_ok = six_ok && arg_bcd_ff[23:16] >= DAY_MIN
                        && arg_bcd_ff[23:16] <= DAY_MAX
                        && arg_bcd_ff[15:8] >= MONTH_MIN
                        && arg_bcd_ff[15:8] <= MONTH_MAX;
      CMD_EMC, CMD_GET, CMD_STO, CMD_MNU, CMD_RUN: cmd_ok = no_arg;
      default: cmd_ok = 1'b0;
    endcase
  end

  // command sequencer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_ff      <= ST_RUN;
      cmd_ff     <= '0;
      ltr_ff     <= '0;
      arg_val_ff <= '0;
      arg_bcd_ff <= '0;
      arg_cnt_ff <= '0;
      arg_bad_ff <= 1'b0;
      arg_ovf_ff <= 1'b0;
      msg_ff     <= MSG_MENU;
      msg_idx_ff <= '0;
    end else if (bang_hit) begin
      st_ff <= ST_IDLE;
    end else begin
      if (tx_go && st_ff == ST_MSG) begin
        msg_idx_ff <= msg_idx_ff + 1'b1;
      end
      case (st_ff)
        ST_RUN: ;
        ST_IDLE: begin
          if (rx_vld_ff && rx_byte_ff == CH_DOLLAR) begin
            st_ff      <= ST_CMD;
            ltr_ff     <= '0;
            arg_val_ff <= '0;
            arg_bcd_ff <= '0;
            arg_cnt_ff <= '0;
            arg_bad_ff <= 1'b0;
            arg_ovf_ff <= 1'b0;
          end
        end
        ST_CMD: begin
          if (rx_vld_ff) begin
            if (ltr_ff != 2'(CMD_LETTERS)) begin
              cmd_ff <= {cmd_ff[15:0], rx_byte_ff};
              ltr_ff <= ltr_ff + 1'b1;
              if (rx_byte_ff == CH_CR) begin
                st_ff      <= ST_MSG;
                msg_ff     <= MSG_ERR;
                msg_idx_ff <= '0;
              end
            end else if (rx_byte_ff == CH_SPACE) begin
              st_ff <= ST_ARG;
            end else if (rx_byte_ff != CH_CR) begin
              st_ff <= ST_SKIP;
            end
          end
        end
        ST_ARG: begin
          if (rx_vld_ff && rx_byte_ff != CH_CR) begin
            if (!is_digit) begin
              arg_bad_ff <= 1'b1;
            end else begin
              arg_bcd_ff <= {arg_bcd_ff[19:0], rx_byte_ff[3:0]};
              if (arg_cnt_ff != '1) begin
                arg_cnt_ff <= arg_cnt_ff + 1'b1;
              end
              if (val_x10 > ARG_MAX) begin
                arg_ovf_ff <= 1'b1;
              end else begin
                arg_val_ff <= val_x10[16:0];
              end
            end
          end
        end
        ST_SKIP: begin
          if (rx_vld_ff && rx_byte_ff == CH_CR) begin
            st_ff      <= ST_MSG;
            msg_ff     <= MSG_ERR;
            msg_idx_ff <= '0;
          end
        end
        ST_ERASE: begin
          if (erase_done_i) begin
            st_ff      <= ST_MSG;
            msg_ff     <= MSG_MENU;
            msg_idx_ff <= '0;
          end
        end
        ST_DUMP: begin
          if (dump_last) begin
            st_ff      <= ST_MSG;
            msg_ff     <= MSG_ETX;
            msg_idx_ff <= '0;
          end
        end
        ST_MSG: begin
          if (msg_end) begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      if (exec) begin
        msg_idx_ff <= '0;
        if (!cmd_ok) begin
          st_ff  <= ST_MSG;
          msg_ff <= MSG_ERR;
        end else begin
          case (cmd_ff)
            CMD_EMC: st_ff <= ST_ERASE;
            CMD_GET: st_ff <= ST_DUMP;
            CMD_RUN: st_ff <= ST_RUN;
            CMD_MNU: begin
              st_ff  <= ST_MSG;
              msg_ff <= MSG_MENU;
            end
            default: st_ff <= ST_IDLE;
          endcase
        end
      end
    end
  end

  assign sampling_o = st_ff == ST_RUN;

  // configuration store; only a checked command reaches it
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      avg_count_o     <= AVE_RST;
      pkt_readings_o  <= PKT_RST;
      burst_packets_o <= SET_RST;
      pkt_interval_o  <= INT_RST;
      rtc_time_o      <= RTC_RST;
      rtc_date_o      <= RTC_RST;
    end else if (exec && cmd_ok && !bang_hit) begin
      case (cmd_ff)
        CMD_AVE: avg_count_o     <= arg_val_ff[15:0];
        CMD_PKT: pkt_readings_o  <= arg_val_ff[15:0];
        CMD_SET: burst_packets_o <= arg_val_ff[15:0];
        CMD_INT: pkt_interval_o  <= arg_bcd_ff;
        CMD_CLK: rtc_time_o      <= arg_bcd_ff;
        CMD_DAT: rtc_date_o      <= arg_bcd_ff;
        default: ;
      endcase
    end
  end

  // one-cycle strobes toward the clock, flash and memory engines, plus the command error strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rtc_time_load_o <= 1'b0;
      rtc_date_load_o <= 1'b0;
      erase_req_o     <= 1'b0;
      dump_req_o      <= 1'b0;
      save_cfg_o      <= 1'b0;
      cmd_error_o     <= 1'b0;
    end else begin
      rtc_time_load_o <= exec && cmd_ok && !bang_hit && cmd_ff == CMD_CLK;
      rtc_date_load_o <= exec && cmd_ok && !bang_hit && cmd_ff == CMD_DAT;
      erase_req_o     <= exec && cmd_ok && !bang_hit && cmd_ff == CMD_EMC;
      dump_req_o      <= exec && cmd_ok && !bang_hit && cmd_ff == CMD_GET;
      save_cfg_o      <= exec && cmd_ok && !bang_hit && cmd_ff == CMD_STO;
      cmd_error_o     <= !bang_hit && rx_vld_ff && rx_byte_ff == CH_CR
                         && ((exec && !cmd_ok) || st_ff == ST_SKIP
                             || (st_ff == ST_CMD && ltr_ff != 2'(CMD_LETTERS)));
    end
  end
endmodule

// >>> test/ssp_asserts.sv
// port checks for the serial setup command parser
// bound into every parser instance; sees only its ports
`timescale 1ns/1ps
module ssp_asserts
  import cmd_pkg::*;
#(
  parameter int DUMP_DEPTH = FIFO_DEPTH,
  parameter int BIT_TIME   = BIT_CYC
) (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        tx_o,
  input wire logic        sampling_o,
  input wire logic [15:0] avg_count_o,
  input wire logic [15:0] pkt_readings_o,
  input wire logic [15:0] burst_packets_o,
  input wire logic [23:0] pkt_interval_o,
  input wire logic [23:0] rtc_time_o,
  input wire logic        rtc_time_load_o,
  input wire logic [23:0] rtc_date_o,
  input wire logic        rtc_date_load_o,
  input wire logic        erase_req_o,
  input wire logic        erase_done_i,
  input wire logic        dump_req_o,
  input wire logic        save_cfg_o,
  input wire logic        cmd_error_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] low_ff;
  // low run length of tx; a whole number of bit times per low stretch
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || tx_o) begin
      low_ff <= 16'h0000;
    end else begin
      low_ff <= low_ff + 16'h0001;
    end
  end
  sequence s_erase_pending;
    erase_req_o ##1 !erase_done_i [*8];
  endsequence
  property p_rst_idle;
    $fell(sys_rst_i) |-> tx_o && sampling_o && avg_count_o == AVE_RST;
  endproperty
  property p_bit_len;
    $rose(tx_o) && low_ff != 16'h0000 |-> low_ff % BIT_TIME == 0;
  endproperty
  property p_err_keep;
    cmd_error_o |-> $stable(avg_count_o) && $stable(pkt_readings_o) &&
      $stable(burst_packets_o) && $stable(pkt_interval_o) && !rtc_time_load_o;
  endproperty
  property p_ave_min;
    avg_count_o != 16'h0000;
  endproperty
  property p_time;
    rtc_time_load_o |-> rtc_time_o[23:16] <= HOUR_MAX && rtc_time_o[15:8] <= MINSEC_MAX
      && rtc_time_o[7:0] <= MINSEC_MAX ##1 $stable(rtc_time_o);
  endproperty
  property p_date;
    rtc_date_load_o |-> rtc_date_o[23:16] inside {[DAY_MIN:DAY_MAX]} &&
      rtc_date_o[15:8] inside {[MONTH_MIN:MONTH_MAX]};
  endproperty
  property p_erase;
    s_erase_pending |-> tx_o;
  endproperty
  property p_pulse;
    erase_req_o || dump_req_o || save_cfg_o |=> !(erase_req_o || dump_req_o || save_cfg_o);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bad state after reset");
  a_bit_len: assert property (p_bit_len) else $error("tx low not whole bits");
  a_err_keep: assert property (p_err_keep) else $error("config moved on error");
  a_ave_min: assert property (p_ave_min) else $error("average count zero");
  a_time: assert property (p_time) else $error("bad time load");
  a_date: assert property (p_date) else $error("bad date load");
  a_erase: assert property (p_erase) else $error("reply before erase done");
  a_pulse: assert property (p_pulse) else $error("request held too long");
endmodule
bind serial_setup_command_parser ssp_asserts #(.DUMP_DEPTH(DUMP_DEPTH), .BIT_TIME(BIT_TIME))
  i_chk (.*);

// >>> test/host_term.sv
// host terminal model: sends text on rx, decodes replies from tx
// assumes 8n1 at the parser bit time on the core clock
`timescale 1ns/1ps
module host_term
  import cmd_pkg::*;
#(
  parameter int BIT_TIME = BIT_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got_q[$];
  initial line_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < FRAME_BITS; i++) begin
      line_o <= fr[i];
      repeat (BIT_TIME) @(posedge core_clk_i);
    end
  endtask
  task automatic send_str(input string s);
    foreach (s[i]) send_byte(s[i]);
  endtask
  // bad stop bit drops the byte, so the bench sees it missing
  initial forever begin
    logic [7:0] b;
    @(negedge line_i);
    repeat (BIT_TIME / 2) @(posedge core_clk_i);
    for (int i = 0; i < DATA_BITS; i++) begin
      repeat (BIT_TIME) @(posedge core_clk_i);
      b[i] = line_i;
    end
    repeat (BIT_TIME) @(posedge core_clk_i);
    if (line_i) got_q.push_back(b);
  end
endmodule

// >>> test/test_serial_setup_command_parser.sv
// self-checking bench for the serial setup command parser
// host model on the serial pins, memory engine and log source here
`timescale 1ns/1ps
module test_serial_setup_command_parser import cmd_pkg::*;;
  localparam int DEPTH = 4;
  // short bit time: the real one would need over a million cycles for this script
  localparam int BT    = 32;
  localparam int LIMIT = 60_000;
  logic        core_clk_i, sys_rst_i, rx_i, tx_o, sampling_o, erase_done_i;
  logic        rtc_time_load_o, rtc_date_load_o, erase_req_o, dump_req_o, save_cfg_o;
  logic        cmd_error_o, log_last_i, log_valid_i, log_ready_o;
  logic [7:0]  log_data_i;
  logic [15:0] avg_count_o, pkt_readings_o, burst_packets_o;
  logic [23:0] pkt_interval_o, rtc_time_o, rtc_date_o;
  logic [7:0]  exp_q[$], dump_q[$];
  int          fails = 0, check_count = 0, cyc = 0, ers = 0, n_ers = 0;
  int          n_err = 0, n_ld = 0, e_err = 0, e_ld = 0, n_sv = 0;

  serial_setup_command_parser #(.DUMP_DEPTH(DEPTH), .BIT_TIME(BT)) i_dut (.*);
  host_term #(.BIT_TIME(BT)) i_host (.core_clk_i(core_clk_i), .line_i(tx_o), .line_o(rx_i));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // memory engine: erase finishes 40 cycles after the request
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    n_err <= n_err + int'(cmd_error_o === 1'b1);
    n_ld <= n_ld + int'(rtc_time_load_o === 1'b1) + int'(rtc_date_load_o === 1'b1);
    n_ers <= n_ers + int'(erase_req_o === 1'b1);
    n_sv <= n_sv + int'(save_cfg_o === 1'b1) + int'(dump_req_o === 1'b1);
    ers <= (erase_req_o === 1'b1) ? 40 : (ers > 0 ? ers - 1 : 0);
    erase_done_i <= (ers == 1);
    if (cyc == LIMIT) begin
      fails = fails + 1;
      close_out();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bytes must arrive in order; a short reply compares against x
  task automatic expect_tx(input string s);
    foreach (s[i]) exp_q.push_back(s[i]);
    for (int n = 0; n < 200000 && i_host.got_q.size() < exp_q.size(); n++)
      @(posedge core_clk_i);
    while (exp_q.size() > 0)
      check(i_host.got_q.size() ? i_host.got_q.pop_front() : 8'hxx, exp_q.pop_front());
    repeat (BT) @(posedge core_clk_i);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_rst_i = 1'b1;
    log_valid_i = 1'b0;
    log_last_i = 1'b0;
    log_data_i = 8'h00;
    void'($urandom(34396));
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    check({sampling_o, tx_o, log_ready_o}, 3'h7);
    check(avg_count_o, AVE_RST);
    check(pkt_interval_o, INT_RST);
    $display("test reset done");
    @(posedge core_clk_i);
    // log bytes pile up outside a dump until the store refuses
    for (int i = 0; i <= DEPTH + 1; i++) begin
      log_data_i <= 8'($urandom);
      log_last_i <= 1'(i == DEPTH);
      log_valid_i <= 1'b1;
      #1;
      check(log_ready_o, 1'(i <= DEPTH));
      if (i <= DEPTH) dump_q.push_back(log_data_i);
      @(posedge core_clk_i);
    end
    log_valid_i <= 1'b0;
    $display("test fill done");
    i_host.send_str("!!!!!");
    check(sampling_o, 1'b0);
    i_host.send_str("$ave 0\015");
    e_err++;
    expect_tx("?\015\012");
    check(n_err, e_err);
    check(avg_count_o, AVE_RST);
    i_host.send_str("$clk 235959\015");
    i_host.send_str("$dat 311299\015");
    e_ld += 2;
    check(n_ld, e_ld);
    check(rtc_time_o, 24'h235959);
    check(rtc_date_o, 24'h311299);
    i_host.send_str("$pkt 0\015$set 65535\015$int 120000\015$sto\015");
    check(pkt_readings_o, 16'h0000);
    check(burst_packets_o, 16'hffff);
    check(pkt_interval_o, 24'h120000);
    check(n_sv, 1);
    check(n_ld, e_ld);
    $display("test setup done");
    i_host.send_str("$emc\015");
    expect_tx("menu\015\012");
    check(n_ers, 1);
    i_host.send_str("$get\015");
    exp_q = dump_q;
    expect_tx("etx\015\012");
    check(log_ready_o, 1'b1);
    check(n_sv, 2);
    i_host.send_str("$run\015");
    check(sampling_o, 1'b1);
    $display("test dump done");
    close_out();
  end
endmodule
